// >>> rtl/ipc_pkg.sv
package ipc_pkg;

  // pin count and per-pin field widths
  localparam int NPIN = 8;
  localparam int NFUNC = 8;
  localparam int MODE_W = 2;
  localparam int DS_W = 3;
  localparam int FSEL_W = 3;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_OUT = 8'h04;
  localparam logic [7:0] REG_IN = 8'h08;
  localparam logic [7:0] REG_PULLUP = 8'h0C;
  localparam logic [7:0] REG_PULLDN = 8'h10;
  localparam logic [7:0] REG_DEBOUNCE = 8'h14;
  localparam logic [7:0] REG_DRIVE = 8'h18;
  localparam logic [7:0] REG_FUNCSEL = 8'h1C;
  localparam logic [7:0] REG_ANALOG = 8'h20;
  localparam logic [7:0] REG_INT_LEVEL = 8'h24;
  localparam logic [7:0] REG_INT_BOTH = 8'h28;
  localparam logic [7:0] REG_INT_POL = 8'h2C;
  localparam logic [7:0] REG_INT_FLAG = 8'h30;
  localparam logic [7:0] REG_INT_EN = 8'h34;

  // reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [7:0] RST_PIN8 = 8'h00;
  localparam logic [23:0] RST_FIELD24 = 24'h000000;

  // pins that may be routed to the adc
  localparam logic [7:0] ANALOG_CAPABLE = 8'h0F;

  // function code that selects the software output register
  localparam logic [2:0] FSEL_GPIO = 3'h0;

  // de-bounce time and its cycle count at 40 MHz (25 ns)
  localparam int CLK_PERIOD_NS = 25;
  localparam int DB_TIME_NS = 100;
  localparam int DB_CYCLES_INT = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] DB_LAST = 3'(DB_CYCLES_INT - 1);

  // pin drive modes
  typedef enum logic [1:0] {
    IPC_MODE_INPUT = 2'h0,
    IPC_MODE_PUSH_PULL = 2'h1,
    IPC_MODE_OPEN_DRAIN = 2'h2,
    IPC_MODE_RSVD = 2'h3
  } ipc_mode_e;

  // controls toward one pad cell
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic [2:0] drive;
    logic analog;
  } ipc_pad_s;

  // what one peripheral function wants on a pin
  typedef struct packed {
    logic out;
    logic oe;
  } ipc_fn_s;

endpackage : ipc_pkg

// >>> rtl/ipc_debounce.sv
`timescale 1ns/1ps
`default_nettype none

module ipc_debounce (
  input wire logic clk,
  input wire logic reset,
  input wire logic raw,
  input wire logic enable,
  output logic filt
);

  logic [2:0] count;

  // a new level is accepted only after it has held for the whole window
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      filt <= 1'b0;
      count <= 3'h0;
    end
    else if (!enable)
    begin
      filt <= raw;
      count <= 3'h0;
    end
    else if (raw == filt)
    begin
      count <= 3'h0; // glitch shorter than window is dropped
    end
    else if (count == ipc_pkg::DB_LAST)
    begin
      filt <= raw;
      count <= 3'h0;
    end
    else
    begin
      count <= count + 3'h1;
    end
  end

endmodule : ipc_debounce

`default_nettype wire

// >>> rtl/ipc_irq_detect.sv
`timescale 1ns/1ps
`default_nettype none

module ipc_irq_detect (
  input wire logic clk,
  input wire logic reset,
  input wire logic sig,
  input wire logic level_mode,
  input wire logic both_edges,
  input wire logic polarity,
  output logic event_hit
);

  logic prev;
  logic rise;
  logic fall;

  // previous filtered level for edge detection
  always_ff @(posedge clk)
  begin
    if (reset)
      prev <= 1'b0;
    else
      prev <= sig;
  end

  assign rise = sig & ~prev;
  assign fall = ~sig & prev;

  // level: active level holds the event; edge: chosen edge(s) only
  always_comb
  begin
    if (level_mode)
      event_hit = (sig == polarity);
    else if (both_edges)
      event_hit = rise | fall;
    else
      event_hit = polarity ? rise : fall;
  end

endmodule : ipc_irq_detect

`default_nettype wire

// >>> rtl/ipc_io_pin_controller.sv
// What this block does
// - per pin: push-pull, open-drain or high-z input
// - independent weak pull-up and pull-down enables
// - per-pin switchable input de-bounce filter
// - every pin interrupts, level or edge
// - edge mode: rising, falling or both
// - per-pin interrupt enable and sticky flag
// - per-pin selector among the software output and 7 peripheral functions
// - per-pin selectable output drive strength
// - some pins route to adc as analog
// - analog pin bypasses the function selector
`timescale 1ns/1ps
`default_nettype none

module ipc_io_pin_controller (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] pad_in,
  output ipc_pkg::ipc_pad_s [7:0] pad_ctl,
  input wire ipc_pkg::ipc_fn_s [7:0][7:0] periph_drive,
  output logic [7:0] periph_in,
  output logic [7:0] adc_sel,
  output logic irq
);

  // software-visible configuration
  logic [15:0] mode;
  logic [7:0] gpio_out;
  logic [7:0] pull_up;
  logic [7:0] pull_dn;
  logic [7:0] debounce_en;
  logic [23:0] drive;
  logic [23:0] funcsel;
  logic [7:0] analog;
  logic [7:0] int_level;
  logic [7:0] int_both;
  logic [7:0] int_pol;
  logic [7:0] int_flag;
  logic [7:0] int_en;

  // per-pin internals
  logic [7:0] filt;
  logic [7:0] pin_event;
  logic [7:0] next_int_flag;
  logic [7:0] flag_clear;
  ipc_pkg::ipc_pad_s [7:0] next_pad_ctl;
  logic [31:0] next_rdata;
  logic wr_mode;
  logic wr_out;
  logic wr_pullup;
  logic wr_pulldn;
  logic wr_debounce;
  logic wr_drive;
  logic wr_funcsel;
  logic wr_analog;
  logic wr_int_level;
  logic wr_int_both;
  logic wr_int_pol;
  logic wr_int_flag;
  logic wr_int_en;

  // write address decode
  // unmapped and read-only addresses match nothing, so such writes vanish
  assign wr_mode = reg_wr && (reg_addr == ipc_pkg::REG_MODE);
  assign wr_out = reg_wr && (reg_addr == ipc_pkg::REG_OUT);
  assign wr_pullup = reg_wr && (reg_addr == ipc_pkg::REG_PULLUP);
  assign wr_pulldn = reg_wr && (reg_addr == ipc_pkg::REG_PULLDN);
  assign wr_debounce = reg_wr && (reg_addr == ipc_pkg::REG_DEBOUNCE);
  assign wr_drive = reg_wr && (reg_addr == ipc_pkg::REG_DRIVE);
  assign wr_funcsel = reg_wr && (reg_addr == ipc_pkg::REG_FUNCSEL);
  assign wr_analog = reg_wr && (reg_addr == ipc_pkg::REG_ANALOG);
  assign wr_int_level = reg_wr && (reg_addr == ipc_pkg::REG_INT_LEVEL);
  assign wr_int_both = reg_wr && (reg_addr == ipc_pkg::REG_INT_BOTH);
  assign wr_int_pol = reg_wr && (reg_addr == ipc_pkg::REG_INT_POL);
  assign wr_int_flag = reg_wr && (reg_addr == ipc_pkg::REG_INT_FLAG);
  assign wr_int_en = reg_wr && (reg_addr == ipc_pkg::REG_INT_EN);

  // pad mode per pin
  // the reserved mode code behaves as a plain input
  always_ff @(posedge clk)
  begin
    if (reset)
      mode <= ipc_pkg::RST_MODE;
    else if (wr_mode)
      mode <= reg_wdata[15:0];
  end

  // software output data
  always_ff @(posedge clk)
  begin
    if (reset)
      gpio_out <= ipc_pkg::RST_PIN8;
    else if (wr_out)
      gpio_out <= reg_wdata[7:0];
  end

  // weak pulls; both on at once is left to software to avoid
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pull_up <= ipc_pkg::RST_PIN8;
      pull_dn <= ipc_pkg::RST_PIN8;
    end
    else
    begin
      if (wr_pullup)
        pull_up <= reg_wdata[7:0];
      if (wr_pulldn)
        pull_dn <= reg_wdata[7:0];
    end
  end

  // filter enables
  always_ff @(posedge clk)
  begin
    if (reset)
      debounce_en <= ipc_pkg::RST_PIN8;
    else if (wr_debounce)
      debounce_en <= reg_wdata[7:0];
  end

  // drive strength and function select, 3 bits per pin each
  // function code 0 is the software output, the rest come from peripherals
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      drive <= ipc_pkg::RST_FIELD24;
      funcsel <= ipc_pkg::RST_FIELD24;
    end
    else
    begin
      if (wr_drive)
        drive <= reg_wdata[23:0];
      if (wr_funcsel)
        funcsel <= reg_wdata[23:0];
    end
  end

  // analog enable sticks only on pins wired to the adc
  always_ff @(posedge clk)
  begin
    if (reset)
      analog <= ipc_pkg::RST_PIN8;
    else if (wr_analog)
      analog <= reg_wdata[7:0] & ipc_pkg::ANALOG_CAPABLE;
  end

  // interrupt sensing configuration
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      int_level <= ipc_pkg::RST_PIN8;
      int_both <= ipc_pkg::RST_PIN8;
      int_pol <= ipc_pkg::RST_PIN8;
      int_en <= ipc_pkg::RST_PIN8;
    end
    else
    begin
      if (wr_int_level)
        int_level <= reg_wdata[7:0];
      if (wr_int_both)
        int_both <= reg_wdata[7:0];
      if (wr_int_pol)
        int_pol <= reg_wdata[7:0];
      if (wr_int_en)
        int_en <= reg_wdata[7:0];
    end
  end

  // per-pin filter and event detector
  // each pin owns its filter and detector, so pins never disturb each other
  genvar gi;
  generate
    for (gi = 0; gi < ipc_pkg::NPIN; gi++)
    begin : g_pin
      ipc_debounce u_debounce (
        .clk(clk),
        .reset(reset),
        .raw(pad_in[gi]),
        .enable(debounce_en[gi]),
        .filt(filt[gi])
      );

      ipc_irq_detect u_detect (
        .clk(clk),
        .reset(reset),
        .sig(filt[gi]),
        .level_mode(int_level[gi]),
        .both_edges(int_both[gi]),
        .polarity(int_pol[gi]),
        .event_hit(pin_event[gi])
      );
    end
  endgenerate

  // flags: a new event wins over a write-one clear in the same cycle
  // a held level in level mode re-sets its flag, so a clear sticks once it goes
  assign flag_clear = wr_int_flag ? reg_wdata[7:0] : ipc_pkg::RST_PIN8;
  assign next_int_flag = (int_flag & ~flag_clear) | pin_event;

  always_ff @(posedge clk)
  begin
    if (reset)
      int_flag <= ipc_pkg::RST_PIN8;
    else
      int_flag <= next_int_flag;
  end

  // single level request, one cycle after the flag it reflects
  // the extra cycle keeps the request glitch free for the core
  always_ff @(posedge clk)
  begin
    if (reset)
      irq <= 1'b0;
    else
      irq <= |(int_flag & int_en);
  end

  // pad control: function source first, then drive mode, then analog override
  always_comb
  begin
    logic [2:0] sel;
    logic data;
    logic want_oe;
    sel = ipc_pkg::FSEL_GPIO;
    data = 1'b0;
    want_oe = 1'b0;
    next_pad_ctl = '0;
    for (int i = 0; i < ipc_pkg::NPIN; i++)
    begin
      sel = funcsel[i*ipc_pkg::FSEL_W +: ipc_pkg::FSEL_W];
      if (sel == ipc_pkg::FSEL_GPIO)
      begin
        data = gpio_out[i];
        want_oe = (mode[i*ipc_pkg::MODE_W +: ipc_pkg::MODE_W] != ipc_pkg::IPC_MODE_INPUT);
      end
      else
      begin
        data = periph_drive[i][sel].out;
        want_oe = periph_drive[i][sel].oe;
      end
      unique case (ipc_pkg::ipc_mode_e'(mode[i*ipc_pkg::MODE_W +: ipc_pkg::MODE_W]))
        ipc_pkg::IPC_MODE_PUSH_PULL:
        begin
          next_pad_ctl[i].out = data;
          next_pad_ctl[i].oe = want_oe;
        end
        // open-drain: sink low or release, a high comes from the pull or board
        ipc_pkg::IPC_MODE_OPEN_DRAIN:
        begin
          next_pad_ctl[i].out = 1'b0; // only ever pulls low
          next_pad_ctl[i].oe = want_oe & ~data;
        end
        // gpio input stays high impedance; a peripheral may own the direction
        ipc_pkg::IPC_MODE_INPUT,
        ipc_pkg::IPC_MODE_RSVD:
        begin
          next_pad_ctl[i].out = (sel != ipc_pkg::FSEL_GPIO) & data;
          next_pad_ctl[i].oe = (sel != ipc_pkg::FSEL_GPIO) & want_oe;
        end
      endcase
      if (analog[i])
      begin
        next_pad_ctl[i].out = 1'b0; // selector bypassed
        next_pad_ctl[i].oe = 1'b0;
      end
      next_pad_ctl[i].pull_up = pull_up[i];
      next_pad_ctl[i].pull_dn = pull_dn[i];
      next_pad_ctl[i].drive = drive[i*ipc_pkg::DS_W +: ipc_pkg::DS_W];
      next_pad_ctl[i].analog = analog[i];
    end
  end

  // pad controls leave from flops to keep pad timing clean
  always_ff @(posedge clk)
  begin
    if (reset)
      pad_ctl <= '0;
    else
      pad_ctl <= next_pad_ctl;
  end

  // peripheral inputs and adc routing; analog pins are masked out of periph_in only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      periph_in <= ipc_pkg::RST_PIN8;
      adc_sel <= ipc_pkg::RST_PIN8;
    end
    else
    begin
      periph_in <= filt & ~analog;
      adc_sel <= analog;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    unique case (reg_addr)
      ipc_pkg::REG_MODE: next_rdata[15:0] = mode;
      ipc_pkg::REG_OUT: next_rdata[7:0] = gpio_out;
      ipc_pkg::REG_IN: next_rdata[7:0] = filt;
      ipc_pkg::REG_PULLUP: next_rdata[7:0] = pull_up;
      ipc_pkg::REG_PULLDN: next_rdata[7:0] = pull_dn;
      ipc_pkg::REG_DEBOUNCE: next_rdata[7:0] = debounce_en;
      ipc_pkg::REG_DRIVE: next_rdata[23:0] = drive;
      ipc_pkg::REG_FUNCSEL: next_rdata[23:0] = funcsel;
      ipc_pkg::REG_ANALOG: next_rdata[7:0] = analog;
      ipc_pkg::REG_INT_LEVEL: next_rdata[7:0] = int_level;
      ipc_pkg::REG_INT_BOTH: next_rdata[7:0] = int_both;
      ipc_pkg::REG_INT_POL: next_rdata[7:0] = int_pol;
      ipc_pkg::REG_INT_FLAG: next_rdata[7:0] = int_flag;
      ipc_pkg::REG_INT_EN: next_rdata[7:0] = int_en;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // zero outside the answer cycle, so several slaves can be or-ed together
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 32'h00000000;
  end

endmodule : ipc_io_pin_controller

`default_nettype wire

// >>> verif/ipc_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module ipc_board_model (
  input wire logic clk,
  input wire ipc_pkg::ipc_pad_s [7:0] pad_ctl,
  input wire logic [7:0] ext_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in = 8'h00
);
  // pin level: block drive, board drive, pull, else a floating pin flips every cycle
  always @(posedge clk)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_ctl[i].oe)
        pad_in[i] <= pad_ctl[i].out;
      else if (ext_oe[i])
        pad_in[i] <= ext_val[i];
      else if (pad_ctl[i].pull_up ^ pad_ctl[i].pull_dn)
        pad_in[i] <= pad_ctl[i].pull_up;
      else
        pad_in[i] <= ~pad_in[i];
    end
  end
endmodule : ipc_board_model

`default_nettype wire

// >>> verif/ipc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ipc_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire ipc_pkg::ipc_pad_s [7:0] pad_ctl,
  input wire logic [7:0] periph_in,
  input wire logic [7:0] adc_sel,
  input wire logic irq
);
  logic [7:0] oe_v;
  logic [7:0] pu_v;
  logic [23:0] ds_v;
  logic [1:0] mode0;
  logic out0;
  logic [2:0] fs0;
  logic an0;
  logic exp_oe;
  logic exp_out;
  logic plain0;

  // flatten pad structs for whole-port compares
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      oe_v[i] = pad_ctl[i].oe;
      pu_v[i] = pad_ctl[i].pull_up;
      ds_v[i*3 +: 3] = pad_ctl[i].drive;
    end
  end

  // pin 0 shadow, updated on the block's own write edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mode0 <= 2'h0;
      out0 <= 1'b0;
      fs0 <= 3'h0;
      an0 <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ipc_pkg::REG_MODE)
        mode0 <= reg_wdata[1:0];
      if (reg_addr == ipc_pkg::REG_OUT)
        out0 <= reg_wdata[0];
      if (reg_addr == ipc_pkg::REG_FUNCSEL)
        fs0 <= reg_wdata[2:0];
      if (reg_addr == ipc_pkg::REG_ANALOG)
        an0 <= reg_wdata[0];
    end
  end

  // one stage like the pad flop, so expectation and pad line up
  always_ff @(posedge clk)
  begin
    exp_oe <= (mode0 == 2'h1) || (mode0 == 2'h2 && !out0);
    exp_out <= (mode0 == 2'h1) && out0;
    plain0 <= (fs0 == 3'h0) && !an0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_pin_mode: assert property (
    plain0 |-> pad_ctl[0].oe == exp_oe && pad_ctl[0].out == exp_out)
    else $error("pin 0 drive wrong for mode");
  chk_pull_follow: assert property (
    reg_wr && reg_addr == ipc_pkg::REG_PULLUP ##1 !reg_wr |=> pu_v == $past(reg_wdata[7:0], 2))
    else $error("pull-up enables wrong");
  chk_drive_follow: assert property (
    reg_wr && reg_addr == ipc_pkg::REG_DRIVE ##1 !reg_wr |=> ds_v == $past(reg_wdata[23:0], 2))
    else $error("drive strength wrong");
  chk_analog_cap: assert property ((adc_sel & ~ipc_pkg::ANALOG_CAPABLE) == 8'h00)
    else $error("adc route on incapable pin");
  chk_analog_quiet: assert property (((adc_sel & oe_v) | (adc_sel & periph_in)) == 8'h00)
    else $error("analog pin still digital");
  chk_flag_sticky: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
    else $error("request dropped without write");
  chk_irq_masked: assert property (
    reg_wr && reg_addr == ipc_pkg::REG_INT_EN && reg_wdata[7:0] == 8'h00 |-> ##2 !irq)
    else $error("request with all enables off");

  cov_irq: cover property ($rose(irq));
  cov_adc: cover property (adc_sel[0]);
  cov_drive: cover property (pad_ctl[0].oe && pad_ctl[0].out);
endmodule : ipc_monitor

bind ipc_io_pin_controller ipc_monitor i_mon (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_ctl(pad_ctl),
  .periph_in(periph_in), .adc_sel(adc_sel), .irq(irq)
);

`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] pad_in;
  ipc_pkg::ipc_pad_s [7:0] pad_ctl;
  ipc_pkg::ipc_fn_s [7:0][7:0] periph_drive = '0;
  logic [7:0] periph_in;
  logic [7:0] adc_sel;
  logic irq;
  logic [7:0] ext_oe = 8'hFF;
  logic [7:0] ext_val = 8'h00;
  logic [5:0] c;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // rows: level, both, polarity, start level, end level, flag expected
  logic [5:0] irq_case [7] = '{6'h0B, 6'h0C, 6'h05, 6'h2B, 6'h26, 6'h15, 6'h13};

  always #12.5 clk = ~clk;

  ipc_io_pin_controller i_dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_ctl(pad_ctl), .periph_drive(periph_drive), .periph_in(periph_in),
    .adc_sel(adc_sel), .irq(irq)
  );

  ipc_board_model i_board (
    .clk(clk), .pad_ctl(pad_ctl), .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
    n_compared++;
    if (seen !== expd)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, expd, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("reg_%h", a), reg_rdata, e);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic results();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // hang guard, far beyond the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(ipc_pkg::REG_MODE, 32'h0);
    wr(ipc_pkg::REG_IN, 32'hFF);
    wr(8'h3C, 32'hFF);
    rd(ipc_pkg::REG_IN, 32'h0);
    rd(8'h3C, 32'h0);
    // pin 0 push-pull, pin 1 open-drain with pull-up, pin 2 pull-down
    wr(ipc_pkg::REG_MODE, 32'h9);
    wr(ipc_pkg::REG_OUT, 32'h3);
    wr(ipc_pkg::REG_PULLUP, 32'h2);
    wr(ipc_pkg::REG_PULLDN, 32'h4);
    wr(ipc_pkg::REG_DRIVE, 32'h5);
    ext_oe <= 8'hF8;
    tick(4);
    check("oe0", pad_ctl[0].oe, 1);
    check("oe1", pad_ctl[1].oe, 0);
    check("drive", {pad_ctl[1].drive, pad_ctl[0].drive}, 6'h05);
    check("pull_dn2", pad_ctl[2].pull_dn, 1);
    rd(ipc_pkg::REG_IN, 32'h3);
    wr(ipc_pkg::REG_OUT, 32'h0);
    tick(3);
    check("oe1", pad_ctl[1].oe, 1);
    // a short glitch must not pass the filter, a held level must
    wr(ipc_pkg::REG_DEBOUNCE, 32'h8);
    ext_val <= 8'h08;
    tick(2);
    ext_val <= 8'h00;
    tick(3);
    rd(ipc_pkg::REG_IN, 32'h0);
    ext_val <= 8'h08;
    tick(8);
    rd(ipc_pkg::REG_IN, 32'h8);
    for (int k = 0; k < 7; k++)
    begin
      c = irq_case[k];
      ext_val[4] <= c[2];
      wr(ipc_pkg::REG_INT_LEVEL, {27'h0, c[5], 4'h0});
      wr(ipc_pkg::REG_INT_BOTH, {27'h0, c[4], 4'h0});
      wr(ipc_pkg::REG_INT_POL, {27'h0, c[3], 4'h0});
      tick(4);
      wr(ipc_pkg::REG_INT_FLAG, 32'hFF);
      ext_val[4] <= c[1];
      tick(4);
      rd(ipc_pkg::REG_INT_FLAG, {27'h0, c[0], 4'h0});
    end
    wr(ipc_pkg::REG_INT_EN, 32'h10);
    tick(3);
    check("irq", irq, 1);
    wr(ipc_pkg::REG_INT_EN, 32'h0);
    tick(3);
    check("irq", irq, 0);
    wr(ipc_pkg::REG_INT_EN, 32'h10);
    wr(ipc_pkg::REG_INT_FLAG, 32'h10);
    tick(3);
    check("irq", irq, 0);
    // reserved mode code on pin 0 must release the pin like an input
    wr(ipc_pkg::REG_MODE, 32'hB);
    tick(3);
    check("oe0_rsvd", pad_ctl[0].oe, 0);
    // pin 0 as input, each peripheral function in turn owns enable and data
    wr(ipc_pkg::REG_MODE, 32'h8);
    for (int n = 1; n < 8; n++)
    begin
      wr(ipc_pkg::REG_FUNCSEL, 32'(n));
      periph_drive[0] <= 16'h3 << (2 * n);
      tick(3);
      check("fn_oe", pad_ctl[0].oe, 1);
      check("fn_out", pad_ctl[0].out, 1);
    end
    wr(ipc_pkg::REG_FUNCSEL, 32'h0);
    tick(3);
    check("fn_oe", pad_ctl[0].oe, 0);
    wr(ipc_pkg::REG_FUNCSEL, 32'h7);
    wr(ipc_pkg::REG_ANALOG, 32'hFF);
    tick(3);
    check("adc_sel", adc_sel, 8'h0F);
    check("oe0", pad_ctl[0].oe, 0);
    rd(ipc_pkg::REG_ANALOG, 32'hF);
    check("periph_in", periph_in, 8'h10);
    results();
  end
endmodule : testbench

`default_nettype wire
